// File: shared/drru_defines.svh
// Constants of the refresh request unit: register map, field positions, widths
`ifndef DRRU_DEFINES_SVH
`define DRRU_DEFINES_SVH

`define DRRU_ADDR_W        4
`define DRRU_DATA_W        16
`define DRRU_CNT_W         9
`define DRRU_ROW_W         12
`define DRRU_BASE_W        7
`define DRRU_PADDR_W       20
`define DRRU_DIV_W         8

`define DRRU_REG_BASE      4'h0
`define DRRU_REG_INTERVAL  4'h4
`define DRRU_REG_CONTROL   4'h8
`define DRRU_REG_ADDRESS   4'hc

`define DRRU_ENABLE_BIT    15
`define DRRU_CNT_ZERO      9'h000
`define DRRU_CNT_ONE       9'h001
`define DRRU_ROW_RESET     12'h000
`define DRRU_LFSR_TAPS     12'h829
`define DRRU_DIV_ZERO      8'h00
`define DRRU_DIV_ONE       8'h01

`endif

// File: shared/drru_pkg.sv
// Types of the refresh request unit
`default_nettype none
`include "drru_defines.svh"
package drru_pkg;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_HOLD,
		PH_T1,
		PH_T2,
		PH_T3,
		PH_T4
	} drru_phase_type;

	typedef struct packed {
		logic [`DRRU_DIV_W-1:0]    div;
		logic                      clock_output;
		logic [`DRRU_CNT_W-1:0]    cnt;
		logic [`DRRU_CNT_W-1:0]    interval;
		logic [`DRRU_BASE_W-1:0]   base;
		logic                      enable;
		logic                      pending;
		drru_phase_type            phase;
		logic [`DRRU_PADDR_W-1:0]  addr;
		logic                      ube_n;
		logic                      refresh_indicator_n_n;
		logic                      read_n;
		logic                      hold_acknowledge;
		logic [`DRRU_DATA_W-1:0]   rdata;
	} drru_state_type;

	typedef struct packed {
		logic [`DRRU_ROW_W-1:0]    row;
	} drru_lfsr_state_type;

endpackage
`default_nettype wire

// File: shared/drru_lfsr_if.sv
// Carrier between the refresh engine and its row address counter
`default_nettype none
`include "drru_defines.svh"
interface drru_lfsr_if;
	logic                      advance;
	logic [`DRRU_ROW_W-1:0]    row;

	modport engine (output advance, input row);
	modport counter (input advance, output row);
endinterface
`default_nettype wire

// File: rtl/drru_lfsr.sv
// Twelve-bit feedback counter that walks every row value once per lap
`default_nettype none
`include "drru_defines.svh"
module drru_lfsr (
	input  wire logic     i_clk,
	input  wire logic     i_resetn,
	drru_lfsr_if.counter  lf
);

	drru_pkg::drru_lfsr_state_type cur;
	drru_pkg::drru_lfsr_state_type next_cur;
	logic                          feedback;

	// Zero detect folds the all-zero value into the lap
	always_comb
	begin
		next_cur = cur;
		feedback = (^(cur.row & `DRRU_LFSR_TAPS)) ^ (cur.row[`DRRU_ROW_W-2:0] == 11'h000);
		if (lf.advance)
		begin
			next_cur.row = {cur.row[`DRRU_ROW_W-2:0], feedback};
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cur.row <= `DRRU_ROW_RESET;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign lf.row = cur.row;

	// ****************************************
	// Checks
	// ****************************************
	row_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		lf.advance |=> lf.row != $past(lf.row))
		else $error("Row counter did not step");
	row_still_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!lf.advance |=> $stable(lf.row))
		else $error("Row counter moved without a refresh cycle");

endmodule
`default_nettype wire

// File: rtl/drru_top.sv
// Refresh request engine with bus arbitration and refresh cycle sequencing
`default_nettype none
`include "drru_defines.svh"

// Overview of operation
// - Counter loads interval on clock output fall
// - Decrement to one, reload, raise request
// - Requests continue until disable, reset, powerdown
// - Pending request waits for free bus
// - Refresh outranks unlocked CPU and DMA
// - Refresh outranks hold arbitration
// - Counter runs while request waits
// - Service clears request, advances address
// - No queue: new request overwrites pending
// - Address changes only after refresh cycle
// - Twelve-bit refresh row counter
// - Upper address bits from base value
// - Row bits from full-lap feedback counter
// - Address bit zero forced high
// - Refresh cycle mimics memory read
// - Wide bus: upper byte enable high
// - Narrow bus: refresh indicator low
// - Base never increments on row wrap
// - Disable clears counter and pending request
// - Drop hold acknowledge, refresh after hold ends
module drru_top #(
	parameter int unsigned                 WIDE_BUS    = 1,
	parameter logic [`DRRU_DIV_W-1:0]      CLOCK_OUTPUT_HALF = `DRRU_DIV_ONE
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_resetn,
	input  wire logic [`DRRU_ADDR_W-1:0]   i_reg_addr,
	input  wire logic [`DRRU_DATA_W-1:0]   i_reg_wdata,
	input  wire logic                      i_reg_write,
	input  wire logic                      i_reg_read,
	output logic [`DRRU_DATA_W-1:0]        o_reg_rdata,
	input  wire logic                      i_powerdown,
	input  wire logic                      i_bus_idle,
	input  wire logic                      i_cpu_req,
	input  wire logic                      i_cpu_locked,
	input  wire logic                      i_dma_req,
	input  wire logic                      i_hold,
	input  wire logic                      i_ready,
	output logic                           o_clock_output,
	output logic                           o_cpu_grant,
	output logic                           o_dma_grant,
	output logic                           o_hold_acknowledge,
	output logic                           o_refresh_cycle,
	output logic                           o_read_n,
	output logic [`DRRU_PADDR_W-1:0]       o_address,
	output logic                           o_upper_byte_enable_n,
	output logic                           o_refresh_indicator_n
);

	localparam drru_pkg::drru_state_type RESET_STATE = '{
		div:      `DRRU_DIV_ZERO,
		clock_output:   1'b0,
		cnt:      `DRRU_CNT_ZERO,
		interval: `DRRU_CNT_ZERO,
		base:     7'h00,
		enable:   1'b0,
		pending:  1'b0,
		phase:    drru_pkg::PH_IDLE,
		addr:     20'h00000,
		ube_n:    1'b1,
		refresh_indicator_n_n:   1'b1,
		read_n:   1'b1,
		hold_acknowledge:     1'b0,
		rdata:    16'h0000
	};

	drru_pkg::drru_state_type  cur;
	drru_pkg::drru_state_type  next_cur;
	drru_lfsr_if               lf ();
	logic                      tick;
	logic                      running;
	logic                      want_refresh;
	logic                      new_request;
	logic                      start_refresh;
	logic                      end_refresh;
	logic                      start_hold;

	drru_lfsr u_lfsr (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.lf       (lf.counter)
	);

	// ****************************************
	// Clock output divider
	// ****************************************
	// Tick marks the falling edge of the clock output
	assign tick = cur.clock_output && (cur.div == CLOCK_OUTPUT_HALF - `DRRU_DIV_ONE);

	// ****************************************
	// Arbitration
	// ****************************************
	// Locked CPU sequences keep the bus; all else yields to refresh
	assign running       = cur.enable && !i_powerdown;
	assign want_refresh  = cur.pending && !i_cpu_locked;
	assign start_refresh = (cur.phase == drru_pkg::PH_IDLE) && i_bus_idle && want_refresh;
	assign start_hold    = (cur.phase == drru_pkg::PH_IDLE) && i_bus_idle && !cur.pending && i_hold;
	assign end_refresh   = (cur.phase == drru_pkg::PH_T4) && tick;
	assign new_request   = tick && running && (cur.cnt == `DRRU_CNT_ONE);

	assign o_cpu_grant = (cur.phase == drru_pkg::PH_IDLE) && i_bus_idle && !want_refresh && !i_hold && i_cpu_req;
	assign o_dma_grant = (cur.phase == drru_pkg::PH_IDLE) && i_bus_idle && !cur.pending && !i_hold
		&& !i_cpu_req && i_dma_req;

	assign lf.advance = end_refresh;

	always_comb
	begin
		next_cur = cur;

		if (cur.div == CLOCK_OUTPUT_HALF - `DRRU_DIV_ONE)
		begin
			next_cur.div    = `DRRU_DIV_ZERO;
			next_cur.clock_output = !cur.clock_output;
		end
		else
		begin
			next_cur.div = cur.div + `DRRU_DIV_ONE;
		end

		if (tick && running && (cur.cnt == `DRRU_CNT_ZERO))
		begin
			next_cur.cnt = cur.interval;
		end
		else if (new_request)
		begin
			next_cur.cnt = cur.interval;
		end
		else if (tick && running)
		begin
			next_cur.cnt = cur.cnt - `DRRU_CNT_ONE;
		end

		if (start_refresh)
		begin
			next_cur.pending = 1'b0;
		end
		if (new_request)
		begin
			next_cur.pending = 1'b1;
		end

		case (cur.phase)
			drru_pkg::PH_IDLE:
			begin
				if (start_refresh)
				begin
					next_cur.phase = drru_pkg::PH_T1;
					next_cur.addr  = {cur.base, lf.row, 1'b1};
					next_cur.refresh_indicator_n_n = (WIDE_BUS != 0);
					next_cur.ube_n  = 1'b1;
				end
				else if (start_hold)
				begin
					next_cur.phase = drru_pkg::PH_HOLD;
					next_cur.hold_acknowledge  = 1'b1;
				end
			end
			drru_pkg::PH_HOLD:
			begin
				if (cur.pending || new_request)
				begin
					next_cur.hold_acknowledge = 1'b0;
				end
				if (!i_hold)
				begin
					next_cur.phase = drru_pkg::PH_IDLE;
					next_cur.hold_acknowledge  = 1'b0;
				end
			end
			drru_pkg::PH_T1:
			begin
				if (tick)
				begin
					next_cur.phase  = drru_pkg::PH_T2;
					next_cur.read_n = 1'b0;
				end
			end
			drru_pkg::PH_T2:
			begin
				if (tick)
				begin
					next_cur.phase = drru_pkg::PH_T3;
				end
			end
			drru_pkg::PH_T3:
			begin
				// Wait states stretch this state
				if (tick && i_ready)
				begin
					next_cur.phase  = drru_pkg::PH_T4;
					next_cur.read_n = 1'b1;
				end
			end
			drru_pkg::PH_T4:
			begin
				if (tick)
				begin
					next_cur.phase  = drru_pkg::PH_IDLE;
					next_cur.refresh_indicator_n_n = 1'b1;
				end
			end
			default:
			begin
				next_cur.phase = drru_pkg::PH_IDLE;
			end
		endcase

		// ****************************************
		// Register port
		// ****************************************
		if (i_reg_write)
		begin
			case (i_reg_addr)
				`DRRU_REG_BASE:     next_cur.base     = i_reg_wdata[`DRRU_BASE_W-1:0];
				`DRRU_REG_INTERVAL: next_cur.interval = i_reg_wdata[`DRRU_CNT_W-1:0];
				`DRRU_REG_CONTROL:  next_cur.enable   = i_reg_wdata[`DRRU_ENABLE_BIT];
				default:            next_cur.enable   = cur.enable;
			endcase
		end

		if (!next_cur.enable)
		begin
			next_cur.cnt     = `DRRU_CNT_ZERO;
			next_cur.pending = 1'b0;
		end

		next_cur.rdata = 16'h0000;
		if (i_reg_read)
		begin
			case (i_reg_addr)
				`DRRU_REG_BASE:     next_cur.rdata = {9'h000, cur.base};
				`DRRU_REG_INTERVAL: next_cur.rdata = {7'h00, cur.interval};
				`DRRU_REG_CONTROL:  next_cur.rdata = {cur.enable, 6'h00, cur.cnt};
				`DRRU_REG_ADDRESS:  next_cur.rdata = {3'h0, lf.row, 1'b1};
				default:            next_cur.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cur <= RESET_STATE;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign o_reg_rdata           = cur.rdata;
	assign o_clock_output        = cur.clock_output;
	assign o_hold_acknowledge    = cur.hold_acknowledge;
	assign o_refresh_cycle       = (cur.phase != drru_pkg::PH_IDLE) && (cur.phase != drru_pkg::PH_HOLD);
	assign o_read_n              = cur.read_n;
	assign o_address             = cur.addr;
	assign o_upper_byte_enable_n = cur.ube_n;
	assign o_refresh_indicator_n = cur.refresh_indicator_n_n;

	// ****************************************
	// Checks
	// ****************************************
	load_on_fall_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(tick && running && cur.cnt == `DRRU_CNT_ZERO && !i_reg_write) |=> cur.cnt == $past(cur.interval))
		else $error("Counter did not load the interval");
	reload_request_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(new_request && !i_reg_write) |=> cur.pending && cur.cnt == $past(cur.interval))
		else $error("No request or reload at count one");
	count_runs_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(tick && running && cur.cnt > `DRRU_CNT_ONE && !i_reg_write) |=> cur.cnt == $past(cur.cnt) - 9'h001)
		else $error("Counter did not step down");
	disable_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_reg_write && i_reg_addr == `DRRU_REG_CONTROL && !i_reg_wdata[`DRRU_ENABLE_BIT])
		|=> cur.cnt == `DRRU_CNT_ZERO && !cur.pending)
		else $error("Disable left counter or request");
	cycle_address_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		start_refresh |=> o_address == {$past(cur.base), $past(lf.row), 1'b1})
		else $error("Refresh address not formed from base and row");
	bit_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_refresh_cycle |-> o_address[0])
		else $error("Address bit zero low in refresh");
	marking_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_refresh_cycle |-> o_upper_byte_enable_n && (o_refresh_indicator_n == (WIDE_BUS != 0)))
		else $error("Refresh cycle marking wrong");
	priority_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		((o_cpu_grant && !i_cpu_locked) || o_dma_grant || start_hold) |-> !cur.pending)
		else $error("Grant given over refresh");
	hold_rank_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(cur.pending && cur.phase == drru_pkg::PH_IDLE) |=> cur.phase != drru_pkg::PH_HOLD)
		else $error("Hold granted over pending refresh");
	base_fixed_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!(i_reg_write && i_reg_addr == `DRRU_REG_BASE) |=> $stable(cur.base))
		else $error("Refresh base moved without a write");
	hold_back_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(cur.phase == drru_pkg::PH_HOLD && cur.pending) |=> !o_hold_acknowledge)
		else $error("Hold acknowledge kept despite refresh");
	service_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(cur.pending && cur.phase == drru_pkg::PH_IDLE && !i_bus_idle && !new_request && cur.enable
		&& !i_reg_write) |=> cur.pending)
		else $error("Request dropped before service");
	read_like_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!o_read_n |-> (cur.phase == drru_pkg::PH_T2 || cur.phase == drru_pkg::PH_T3))
		else $error("Read strobe outside refresh body");

	refresh_done_c: cover property (@(posedge i_clk) disable iff (!i_resetn) end_refresh);
	hold_return_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
		(cur.phase == drru_pkg::PH_HOLD && cur.pending) ##[1:50] start_refresh);
	lost_request_c: cover property (@(posedge i_clk) disable iff (!i_resetn) cur.pending && new_request);
	locked_defer_c: cover property (@(posedge i_clk) disable iff (!i_resetn) cur.pending && i_cpu_locked && o_cpu_grant);

endmodule
`default_nettype wire

// File: tb/drru_dram_model.sv
// Behavioural external DRAM controller that answers refresh cycles
`default_nettype none
module drru_dram_model (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_refresh_cycle,
	input  wire logic        i_read_n,
	input  wire logic [19:0] i_address,
	input  wire logic        i_upper_byte_enable_n,
	input  wire logic [3:0]  i_waits,
	output logic             o_ready,
	output logic             o_ras_n,
	output logic             o_cas_n,
	output int               o_refreshes
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wcnt;
	logic       hit;
	assign hit = i_refresh_cycle && !i_read_n && i_address[0] && i_upper_byte_enable_n;
	// Wait states end after i_waits cycles
	assign o_ready = !i_read_n && (wcnt >= i_waits);
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			wcnt <= 4'h0;
			o_ras_n <= 1'b1;
			o_cas_n <= 1'b1;
			o_refreshes <= 0;
		end
		else if (hit)
		begin
			if (wcnt != 4'hf)
				wcnt <= wcnt + 4'h1;
			if (o_ras_n)
				o_refreshes <= o_refreshes + 1;
			o_ras_n <= 1'b0;
			o_cas_n <= o_ras_n;
		end
		else
		begin
			wcnt <= 4'h0;
			o_ras_n <= 1'b1;
			o_cas_n <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: tb/drru_top_tb.sv
// Self-checking bench of the refresh request unit
`default_nettype none
`include "drru_defines.svh"
module drru_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  ra = 4'h0;
	logic [15:0] wd = 16'h0000;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        pd = 1'b0;
	logic        idle = 1'b1;
	logic        cpu = 1'b0;
	logic        dma = 1'b0;
	logic        hold = 1'b0;
	logic        lck = 1'b0;
	logic [3:0]  waits = 4'h3;
	logic [15:0] rdat;
	logic [19:0] adr;
	logic [19:0] adr8;
	logic        rdy, cg, dg, hold_acknowledge, rc, rn, ube, rf, rc8, rf8, co;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          nref;
	bit          seen [4096];
	drru_top #(.WIDE_BUS(1)) dut_u (
		.i_clk(clk), .i_resetn(rstn), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_write(wr_s),
		.i_reg_read(rd_s), .o_reg_rdata(rdat), .i_powerdown(pd), .i_bus_idle(idle), .i_cpu_req(cpu),
		.i_cpu_locked(lck), .i_dma_req(dma), .i_hold(hold), .i_ready(rdy), .o_clock_output(co),
		.o_cpu_grant(cg), .o_dma_grant(dg), .o_hold_acknowledge(hold_acknowledge), .o_refresh_cycle(rc),
		.o_read_n(rn), .o_address(adr), .o_upper_byte_enable_n(ube), .o_refresh_indicator_n(rf));
	// Narrow bus twin fed the same stimulus
	drru_top #(.WIDE_BUS(0)) dut8_u (
		.i_clk(clk), .i_resetn(rstn), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_write(wr_s),
		.i_reg_read(rd_s), .o_reg_rdata(), .i_powerdown(pd), .i_bus_idle(idle), .i_cpu_req(cpu),
		.i_cpu_locked(lck), .i_dma_req(dma), .i_hold(hold), .i_ready(rdy), .o_clock_output(),
		.o_cpu_grant(), .o_dma_grant(), .o_hold_acknowledge(), .o_refresh_cycle(rc8),
		.o_read_n(), .o_address(adr8), .o_upper_byte_enable_n(), .o_refresh_indicator_n(rf8));
	drru_dram_model mdl_u (
		.i_clk(clk), .i_resetn(rstn), .i_refresh_cycle(rc), .i_read_n(rn), .i_address(adr),
		.i_upper_byte_enable_n(ube), .i_waits(waits), .o_ready(rdy), .o_ras_n(), .o_cas_n(),
		.o_refreshes(nref));
	always #5 clk = ~clk;
	// ****************
	// Helpers
	// ****************
	task automatic complete_run();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [19:0] seen_v, input logic [19:0] exp);
		cmp_count++;
		if (seen_v !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		ra <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdat;
	endtask
	// Bounded wait on refresh_cycle (0) or hold acknowledge (1)
	task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
		n = 0;
		while ((sel == 0 ? rc : hold_acknowledge) !== lvl && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 60000)
		begin
			num_errors++;
			complete_run();
		end
	end
	// ****************
	// Scenarios
	// ****************
	initial
	begin
		logic [15:0] d;
		logic [15:0] d2;
		logic [15:0] r0;
		int          n;
		int          m;
		int          dups;
		int          n0;
		logic        co0;
		dups = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(`DRRU_REG_CONTROL, d);
		chk("control", 20'(d), 20'h0);
		rd(4'h2, d);
		chk("unmapped", 20'(d), 20'h0);
		wr(`DRRU_REG_ADDRESS, 16'hfffe);
		rd(`DRRU_REG_ADDRESS, d);
		chk("addr_reg", 20'(d), 20'h1);
		wr(`DRRU_REG_BASE, 16'h0055);
		wr(`DRRU_REG_INTERVAL, 16'h0014);
		rd(`DRRU_REG_ADDRESS, r0);
		@(posedge clk);
		cpu <= 1'b1;
		dma <= 1'b1;
		wr(`DRRU_REG_CONTROL, 16'h8000);
		wait_sig(0, 1'b1, 100, n);
		chk("refresh", 20'(rc), 20'h1);
		chk("address", adr, {7'h55, r0[12:1], 1'b1});
		chk("ube_n", 20'({ube, rf}), 20'h3);
		chk("grants", 20'({cg, dg}), 20'h0);
		chk("narrow", 20'({rc8, rf8, adr8[0]}), 20'h5);
		wait_sig(0, 1'b0, 100, n);
		chk("cpu_grant", 20'(cg), 20'h1);
		rd(`DRRU_REG_ADDRESS, d);
		chk("row_step", 20'(d != r0), 20'h1);
		wait_sig(0, 1'b1, 100, n);
		wait_sig(0, 1'b0, 100, n);
		wait_sig(0, 1'b1, 100, m);
		chk("spacing", 20'(n + m), 20'h28);
		// Busy bus: requests lost, address kept
		wait_sig(0, 1'b0, 100, n);
		@(posedge clk);
		idle <= 1'b0;
		rd(`DRRU_REG_ADDRESS, r0);
		rd(`DRRU_REG_CONTROL, d);
		repeat (100) @(posedge clk);
		rd(`DRRU_REG_CONTROL, d2);
		chk("counting", 20'(d2 != d), 20'h1);
		chk("no_cycle", 20'(rc), 20'h0);
		rd(`DRRU_REG_ADDRESS, d);
		chk("kept", 20'(d), 20'(r0));
		// Locked CPU sequence defers the pending refresh
		@(posedge clk);
		lck <= 1'b1;
		idle <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("locked", 20'({rc, cg}), 20'h1);
		@(posedge clk);
		lck <= 1'b0;
		wait_sig(0, 1'b1, 8, n);
		chk("served", adr, {7'h55, r0[12:1], 1'b1});
		wait_sig(0, 1'b0, 100, n);
		// Refresh may run first, so wait for the acknowledge
		@(posedge clk);
		hold <= 1'b1;
		wait_sig(1, 1'b1, 20, n);
		chk("hold_ack", 20'(hold_acknowledge), 20'h1);
		wait_sig(1, 1'b0, 60, n);
		chk("hold_drop", 20'(hold_acknowledge), 20'h0);
		repeat (6) @(posedge clk);
		#1;
		chk("held_off", 20'(rc), 20'h0);
		@(posedge clk);
		hold <= 1'b0;
		wait_sig(0, 1'b1, 8, n);
		chk("after_hold", 20'(rc), 20'h1);
		wait_sig(0, 1'b0, 100, n);
		@(posedge clk);
		pd <= 1'b1;
		rd(`DRRU_REG_CONTROL, d);
		repeat (20) @(posedge clk);
		rd(`DRRU_REG_CONTROL, d2);
		chk("frozen", 20'(d2), 20'(d));
		@(posedge clk);
		pd <= 1'b0;
		wr(`DRRU_REG_CONTROL, 16'h0000);
		rd(`DRRU_REG_CONTROL, d);
		chk("disabled", 20'(d), 20'h0);
		wait_sig(0, 1'b1, 60, n);
		chk("stopped", 20'(rc), 20'h0);
		@(posedge clk);
		cpu <= 1'b0;
		@(posedge clk);
		#1;
		chk("dma_grant", 20'(dg), 20'h1);
		// Full lap: every row once, base never moves
		@(posedge clk);
		waits <= 4'h0;
		wr(`DRRU_REG_INTERVAL, 16'h0006);
		wr(`DRRU_REG_CONTROL, 16'h8000);
		n0 = nref;
		for (int i = 0; i < 4096; i++)
		begin
			wait_sig(0, 1'b1, 40, n);
			if (seen[adr[12:1]] || adr[19:13] !== 7'h55 || adr[0] !== 1'b1)
				dups++;
			seen[adr[12:1]] = 1'b1;
			wait_sig(0, 1'b0, 40, n);
		end
		chk("lap", 20'(dups), 20'h0);
		chk("model", 20'(nref - n0), 20'h1000);
		co0 = co;
		@(posedge clk);
		#1;
		chk("clock_output", 20'(co), 20'(!co0));
		complete_run();
	end
endmodule
`default_nettype wire
